// ===== bench/bsr_host_model.sv
`timescale 1ns/1ps
// smbus host master; half periods of 10 logic clocks, data moved mid low phase
module bsr_host_model (
  input  wire logic i_ref_clk,  // logic clock
  input  wire logic i_sda,      // resolved data wire
  output logic      o_scl,      // serial clock drive
  output logic      o_sda       // data release level, 0 pulls low
);
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // start or repeated start; leaves clock low
  task automatic start;
    tick(5);
    o_sda = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    o_sda = 1'b0;
    tick(10);
    o_scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop;
    tick(5);
    o_sda = 1'b0;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    o_sda = 1'b1;
    tick(10);
  endtask
  // one clock: present b, sample wire mid high phase
  task automatic bit_cyc(input logic b, output logic r);
    tick(5);
    o_sda = b;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    r = i_sda;
    tick(5);
    o_scl = 1'b0;
  endtask
  // byte out msb first, then the ack clock
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(v[i], r);
    end
    bit_cyc(1'b1, r);
    ack = ~r;
  endtask
  // write byte transfer
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    start();
    put_byte(8'h58, a1);
    put_byte(cmd, a2);
    put_byte(d, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask
  // read byte transfer, host ends with a nack
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    logic a1, a2, a3, r;
    start();
    put_byte(8'h58, a1);
    put_byte(cmd, a2);
    start();
    put_byte(8'h59, a3);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, r);
      d[i] = r;
    end
    bit_cyc(1'b1, r);
    stop();
    ok = a1 & a2 & a3;
  endtask
  // address byte alone, reports the ack
  task automatic probe(input logic [7:0] adr, output logic ack);
    start();
    put_byte(adr, ack);
    stop();
  endtask
endmodule

// ===== bench/bsr_smbus_top_props.sv
`timescale 1ns/1ps
// pin-level checker for the status/identification slave
module bsr_smbus_props
  import bsr_pkg::*;
(
  input  wire logic                i_ref_clk,          // logic clock
  input  wire logic                i_rstn,             // async reset, active low
  input  wire logic                i_smb_clk,          // serial clock pin
  input  wire logic                i_smb_data,         // serial data pin
  input  wire logic                o_smb_data_out,     // data drive value
  input  wire logic                o_smb_data_oe,      // data drive enable
  input  wire logic                i_thermal,          // thermal condition
  input  wire logic                i_overcurrent,      // overcurrent condition
  input  wire logic                i_backlight_on,     // backlight lit
  input  wire logic [3:0]          i_faulted_strings,  // disabled string count
  input  wire bsr_pkg::bsr_state_t o_state             // engine state
);
  // all checks on the logic clock, muted in reset except reset_quiet_a
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  out_low_a: assert property (o_smb_data_out == 1'b0)
    else $error("data drive value is not low");
  reset_quiet_a: assert property (disable iff (1'b0) !i_rstn |-> !o_smb_data_oe && o_state == BSR_IDLE)
    else $error("bus not quiet in reset");
  wake_quiet_a: assert property ($rose(i_rstn) |-> !o_smb_data_oe [*4])
    else $error("data driven right after reset");
  state_ok_a: assert property (o_state inside {BSR_IDLE, BSR_RECV, BSR_ACK, BSR_SEND, BSR_MACK})
    else $error("engine state out of range");
  oe_state_a: assert property (o_smb_data_oe |-> o_state inside {BSR_ACK, BSR_SEND} ||
    $past(o_state) inside {BSR_ACK, BSR_SEND}) else $error("data driven outside ack or send");
  idle_quiet_a: assert property (o_state == BSR_IDLE && $past(o_state) == BSR_IDLE |-> !o_smb_data_oe)
    else $error("data driven while idle");
  hold_high_a: assert property (i_smb_clk [*8] |-> $stable(o_smb_data_oe))
    else $error("drive changed while clock high");
  rise_low_a: assert property ($rose(o_smb_data_oe) |-> !i_smb_clk && !$past(i_smb_clk, 2))
    else $error("drive began outside clock low");
  fall_low_a: assert property ($fell(o_smb_data_oe) |-> !i_smb_clk && !$past(i_smb_clk, 2))
    else $error("drive ended outside clock low");
  idle_hold_a: assert property ((i_smb_clk && i_smb_data) [*6] ##0 o_state == BSR_IDLE
    |=> o_state == BSR_IDLE) else $error("engine left idle without start");
endmodule

bind bsr_smbus_top bsr_smbus_props u_props (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_smb_clk(i_smb_clk), .i_smb_data(i_smb_data),
  .o_smb_data_out(o_smb_data_out), .o_smb_data_oe(o_smb_data_oe), .i_thermal(i_thermal),
  .i_overcurrent(i_overcurrent), .i_backlight_on(i_backlight_on),
  .i_faulted_strings(i_faulted_strings), .o_state(o_state)
);

// ===== bench/bsr_smbus_top_test.sv
`timescale 1ns/1ps
// register reads and writes over the serial pins
module bsr_smbus_top_test;
  import bsr_pkg::*;
  localparam logic [3:0] VEND = 4'h5;  // arbitrary vendor value
  localparam logic [2:0] SPIN = 3'h3;  // arbitrary spin value
  logic       clk, rstn, scl, host_sda, sda, d_out, d_oe;  // clock, reset, pins
  logic       th, oc, bl;                                 // condition inputs
  logic [3:0] strs;                                       // faulted string count
  bsr_state_t state;                                      // engine state
  int         err_count, n_tests;                         // mismatches, comparisons
  logic [7:0] rdat;                                       // read data
  logic       ok;                                         // acks seen
  // {thermal, overcurrent, backlight, strings}
  logic [6:0] vec [7] = '{7'h40, 7'h20, 7'h10, 7'h01, 7'h02, 7'h03, 7'h78};
  logic [7:0] bad [3] = '{8'h5a, 8'h48, 8'hd8};           // foreign addresses

  assign sda = ~d_oe & host_sda;  // open drain with pull-up

  bsr_smbus_top #(.VENDOR(VEND), .SPIN(SPIN)) DUT (
    .i_ref_clk(clk), .i_rstn(rstn), .i_smb_clk(scl), .i_smb_data(sda),
    .o_smb_data_out(d_out), .o_smb_data_oe(d_oe), .i_thermal(th), .i_overcurrent(oc),
    .i_backlight_on(bl), .i_faulted_strings(strs), .o_state(state)
  );
  bsr_host_model host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));

  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // status image expected for one input vector
  function automatic logic [7:0] stat_exp(input logic [6:0] v);
    logic [3:0] s;
    s = v[3:0];
    return {2'b00, s > 4'h1, s != 4'h0, v[4], v[5], v[6], v[6] | v[5] | (s != 4'h0)};
  endfunction
  // verdict and end of run
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    complete_run();
  end
  // main sequence
  initial begin
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    {th, oc, bl, strs} = 7'h00;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    host.rd(8'h02, rdat, ok);
    check(rdat, 8'h00);
    check({7'h00, ok}, 8'h01);
    check({7'h00, d_out}, 8'h00);
    check({7'h00, d_oe}, 8'h00);
    check({5'h00, state}, {5'h00, BSR_IDLE});
    host.rd(8'h03, rdat, ok);
    check(rdat, {1'b1, VEND, SPIN});
    foreach (vec[k]) begin
      {th, oc, bl, strs} = vec[k];
      host.rd(8'h02, rdat, ok);
      check(rdat, stat_exp(vec[k]));
    end
    // writes are acked and change nothing
    host.wr(8'h02, 8'hc0, ok);
    check({7'h00, ok}, 8'h01);
    host.rd(8'h02, rdat, ok);
    check(rdat, stat_exp(vec[6]));
    host.wr(8'h03, 8'h00, ok);
    host.rd(8'h03, rdat, ok);
    check(rdat, {1'b1, VEND, SPIN});
    // foreign addresses get no ack
    foreach (bad[i]) begin
      host.probe(bad[i], ok);
      check({7'h00, ok}, 8'h00);
    end
    // unmapped index reads as zero
    host.rd(8'h07, rdat, ok);
    check(rdat, 8'h00);
    complete_run();
  end
endmodule

// ===== common/bsr_params.svh
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

// slave address bytes as seen on the wire, r/w bit included
`define BSR_ADDR_WRITE      8'h58
`define BSR_ADDR_READ       8'h59

// register indices carried by the command code
`define BSR_OFS_STATUS      8'h02
`define BSR_OFS_IDENT       8'h03

// reset and fill values
`define BSR_STATUS_RESET    8'h00
`define BSR_READ_ZERO       8'h00

// status field positions
`define BSR_ST_SUMMARY      0
`define BSR_ST_THERMAL      1
`define BSR_ST_OVERCURRENT  2
`define BSR_ST_BACKLIGHT    3
`define BSR_ST_STRING_LO    4
`define BSR_ST_STRING_HI    5

// string fault encodings
`define BSR_STRINGS_NONE    2'b00
`define BSR_STRINGS_ONE     2'b01
`define BSR_STRINGS_MULTI   2'b11
`define BSR_STRING_CNT_ONE  4'h1

// identification fields and values
`define BSR_ID_PANEL_BIT    7
`define BSR_ID_PANEL_LED    1'b1
`define BSR_VENDOR_CODE     4'h9
`define BSR_SPIN_FIRST      3'h0

// bit count of one serial byte
`define BSR_BITS_PER_BYTE   4'h8
`define BSR_BYTE_MSB        7

// positions in the synchronised pin bundle
`define BSR_PIN_SCL         0
`define BSR_PIN_SDA         1
`define BSR_PIN_THERMAL     2
`define BSR_PIN_OVERCUR     3
`define BSR_PIN_BACKLIGHT   4
`define BSR_PIN_STR_LO      5
`define BSR_PIN_STR_HI      8
// bundle level in reset: bus lines high, conditions low
`define BSR_PIN_IDLE        9'h003

`endif

// ===== common/bsr_pkg.sv
package bsr_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    BSR_IDLE = 3'b000,
    BSR_RECV = 3'b001,
    BSR_ACK  = 3'b010,
    BSR_SEND = 3'b011,
    BSR_MACK = 3'b100
  } bsr_state_t;

  // which byte of a transfer is being received
  typedef enum logic [1:0] {
    BSR_KIND_ADDR = 2'b00,
    BSR_KIND_CMD  = 2'b01,
    BSR_KIND_DATA = 2'b10
  } bsr_kind_t;

  typedef logic [7:0] bsr_byte_t;

endpackage

// ===== common/bsr_reg_if.sv
`timescale 1ns/1ps
// read path between serial engine and register bank
interface bsr_reg_if;
  bsr_pkg::bsr_byte_t index;    // register index from command code
  bsr_pkg::bsr_byte_t rd_data;  // value of indexed register

  modport engine (output index, input rd_data);
  modport bank   (input index, output rd_data);
endinterface

// ===== rtl/bsr_pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module bsr_pin_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_ref_clk,  // logic clock
  input  wire logic             i_rstn,     // async reset, active low
  input  wire logic [WIDTH-1:0] i_async,    // raw pin levels
  output logic      [WIDTH-1:0] o_sync      // filtered synchronous levels
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;    // sync stages
  logic [WIDTH-1:0] out_reg, out_next;          // accepted level

  // accept a bit only when the two late stages agree
  always_comb begin
    out_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (out_reg & (s2_reg ^ s3_reg));
  end

  // stage one feeds stage two only
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg  <= RESET_VAL;
      s2_reg  <= RESET_VAL;
      s3_reg  <= RESET_VAL;
      out_reg <= RESET_VAL;
    end else begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;
endmodule

// ===== rtl/bsr_reg_bank.sv
`timescale 1ns/1ps
`include "bsr_params.svh"
// fault/status and identification registers, both read only
module bsr_reg_bank #(
  parameter logic [3:0] VENDOR = `BSR_VENDOR_CODE,  // arbitrary vendor value
  parameter logic [2:0] SPIN   = `BSR_SPIN_FIRST    // silicon spin value
) (
  input  wire logic       i_ref_clk,         // logic clock
  input  wire logic       i_rstn,            // async reset, active low
  input  wire logic       i_thermal,         // thermal shutdown active
  input  wire logic       i_overcurrent,     // input overcurrent active
  input  wire logic       i_backlight_on,    // backlight is lit
  input  wire logic [3:0] i_faulted_strings, // count of disabled strings
  bsr_reg_if.bank         regs               // read port to engine
);
  import bsr_pkg::*;

  bsr_byte_t status_reg, status_next;  // live status image
  logic [1:0] string_code;             // encoded string fault count
  logic       any_fault;               // summary of fault conditions
  bsr_byte_t  ident;                   // fixed identification value

  // encode string count and build status image
  always_comb begin
    if (i_faulted_strings == '0) begin
      string_code = `BSR_STRINGS_NONE;
    end else if (i_faulted_strings == `BSR_STRING_CNT_ONE) begin
      string_code = `BSR_STRINGS_ONE;
    end else begin
      string_code = `BSR_STRINGS_MULTI;
    end
    any_fault   = i_thermal | i_overcurrent | (string_code != `BSR_STRINGS_NONE);
    status_next = `BSR_READ_ZERO;               // reserved bits stay zero
    status_next[`BSR_ST_SUMMARY]     = any_fault;
    status_next[`BSR_ST_THERMAL]     = i_thermal;
    status_next[`BSR_ST_OVERCURRENT] = i_overcurrent;
    status_next[`BSR_ST_BACKLIGHT]   = i_backlight_on;
    status_next[`BSR_ST_STRING_HI:`BSR_ST_STRING_LO] = string_code;
  end

  // status follows conditions only, never bus writes
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_reg <= `BSR_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // panel bit, vendor field, spin field; constant wiring
  assign ident = {`BSR_ID_PANEL_LED, VENDOR, SPIN};

  // read decode; other indices read zero
  always_comb begin
    case (regs.index)
      `BSR_OFS_STATUS: regs.rd_data = status_reg;
      `BSR_OFS_IDENT:  regs.rd_data = ident;
      default:         regs.rd_data = `BSR_READ_ZERO;
    endcase
  end
endmodule

// ===== rtl/bsr_smbus_top.sv
`timescale 1ns/1ps
`include "bsr_params.svh"
// Overview of operation
// - status: bits 7..6 reserved, reset 0x00
// - string bits encode count: 00, 01, 11
// - bit 3 shows backlight on state
// - bit 2 shows input overcurrent
// - bit 1 shows thermal shutdown fault
// - bit 0 is OR of all faults
// - identification: 4-bit vendor, 3-bit revision
// - revision field sits in bits 2..0
// - revision starts at 0, steps by 1
// - identification bit 7 reads constant 1
// - vendor field in bits 6..3, fixed
// - identification register ignores host writes
// - read/write byte, command code is index
// - answer address bytes 0x58 and 0x59
// - reserved status bits read 0, writes ignored
module bsr_smbus_top #(
  parameter logic [3:0] VENDOR = `BSR_VENDOR_CODE,  // arbitrary vendor value
  parameter logic [2:0] SPIN   = `BSR_SPIN_FIRST    // silicon spin value
) (
  input  wire logic       i_ref_clk,          // 20 mhz logic clock
  input  wire logic       i_rstn,             // async reset, active low
  input  wire logic       i_smb_clk,          // serial clock pin level
  input  wire logic       i_smb_data,         // serial data pin level
  output logic            o_smb_data_out,     // data pin drive value
  output logic            o_smb_data_oe,      // data pin drive enable
  input  wire logic       i_thermal,          // thermal shutdown condition
  input  wire logic       i_overcurrent,      // input overcurrent condition
  input  wire logic       i_backlight_on,     // backlight lit
  input  wire logic [3:0] i_faulted_strings,  // count of disabled strings
  output bsr_pkg::bsr_state_t o_state         // engine state, for debug
);
  import bsr_pkg::*;

  // no clock stretching: each answer must be ready within one low phase,
  // which the four-clock pin pipeline meets while the master keeps every
  // half period at eight clocks or more
  // three conditions, the string count and the two bus lines
  localparam int SYNC_W = 9;  // pins passing the synchroniser

  // synchronised pins
  logic [SYNC_W-1:0] pins_raw;      // raw pin bundle
  logic [SYNC_W-1:0] pins_sync;     // synchronised bundle
  logic              scl_s;         // serial clock, synchronous
  logic              sda_s;         // serial data, synchronous
  logic              thermal_s;     // thermal condition, synchronous
  logic              overcur_s;     // overcurrent, synchronous
  logic              bl_on_s;       // backlight state, synchronous
  logic [3:0]        strings_s;     // string count, synchronous

  // bus line history and events
  logic scl_q_reg, scl_q_next;      // previous serial clock
  logic sda_q_reg, sda_q_next;      // previous serial data
  logic scl_rise;                   // clock rising edge
  logic scl_fall;                   // clock falling edge
  logic bus_start;                  // start or repeated start
  logic bus_stop;                   // stop condition
  // decode of the gathered byte
  logic byte_full;                  // eight bits gathered in shift register
  logic rd_addr;                    // gathered byte is our read address

  // engine state
  bsr_state_t st_reg,    st_next;     // engine state
  bsr_kind_t  kind_reg,  kind_next;   // byte being received
  logic [3:0] bit_reg,   bit_next;    // bits seen in current byte
  bsr_byte_t  shift_reg, shift_next;  // serial shift register
  bsr_byte_t  cmd_reg,   cmd_next;    // last command code
  logic       rw_reg,    rw_next;     // current address was a read
  logic       oe_reg,    oe_next;     // pull data line low
  logic       addr_hit;               // received byte is our address

  // register read path
  // index goes out, register value comes back without a clock
  bsr_reg_if regs ();

  // all outside levels pass three stages
  // bundle order matches the pin positions in the header
  assign pins_raw = {i_faulted_strings, i_backlight_on, i_overcurrent,
                     i_thermal, i_smb_data, i_smb_clk};

  // bus lines idle high, conditions idle low
  // the filter hides spikes shorter than one clock
  bsr_pin_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (`BSR_PIN_IDLE)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (pins_raw),
    .o_sync    (pins_sync)
  );

  // unpack synchronised bundle
  // bus lines first, then the conditions
  assign scl_s     = pins_sync[`BSR_PIN_SCL];
  assign sda_s     = pins_sync[`BSR_PIN_SDA];
  assign thermal_s = pins_sync[`BSR_PIN_THERMAL];
  assign overcur_s = pins_sync[`BSR_PIN_OVERCUR];
  assign bl_on_s   = pins_sync[`BSR_PIN_BACKLIGHT];
  assign strings_s = pins_sync[`BSR_PIN_STR_HI:`BSR_PIN_STR_LO];

  // status and identification storage
  // its inputs are already synchronised, so it needs no filter of its own
  bsr_reg_bank #(
    .VENDOR (VENDOR),
    .SPIN   (SPIN)
  ) u_bank (
    .i_ref_clk         (i_ref_clk),
    .i_rstn            (i_rstn),
    .i_thermal         (thermal_s),
    .i_overcurrent     (overcur_s),
    .i_backlight_on    (bl_on_s),
    .i_faulted_strings (strings_s),
    .regs              (regs)
  );

  // command code selects the register read back
  // the last command code stays in force for a read that sends none
  assign regs.index = cmd_reg;

  // address decode, shared by acknowledge and direction capture
  function automatic logic is_our_addr(input bsr_byte_t b);
    // either direction of our seven-bit address
    return (b == `BSR_ADDR_WRITE) || (b == `BSR_ADDR_READ);
  endfunction

  // read direction of our address; the r/w bit rides in the lsb
  function automatic logic is_read_addr(input bsr_byte_t b);
    return (b == `BSR_ADDR_READ);
  endfunction

  // history of the synchronous lines, one clock back
  always_comb begin
    scl_q_next = scl_s;
    sda_q_next = sda_s;
  end

  // edge and condition detection on synchronous lines
  always_comb begin
    // both lines share one pipeline, so their edges stay aligned
    scl_rise  = scl_s & ~scl_q_reg;
    scl_fall  = ~scl_s & scl_q_reg;
    // data moving while the clock stays high marks start and stop
    bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  end

  // decode of the gathered byte
  always_comb begin
    byte_full = (bit_reg == `BSR_BITS_PER_BYTE);  // all bits of a byte seen
    addr_hit  = is_our_addr(shift_reg);
    rd_addr   = is_read_addr(shift_reg);
  end

  // serial engine next-state logic
  always_comb begin
    st_next    = st_reg;
    kind_next  = kind_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    cmd_next   = cmd_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    if (bus_start) begin
      // start or repeated start: expect address byte
      // a start in mid byte abandons it; nothing had been stored
      st_next   = BSR_RECV;
      kind_next = BSR_KIND_ADDR;
      bit_next  = '0;
      oe_next   = 1'b0;
    end else if (bus_stop) begin
      // stop ends any transfer and frees the line
      st_next = BSR_IDLE;
      oe_next = 1'b0;
    end else begin
      // states follow the byte and acknowledge rhythm of the bus
      case (st_reg)
        BSR_IDLE: begin
          // wait for a start
          // the data line stays released between transfers
          oe_next = 1'b0;
        end
        BSR_RECV: begin
          // gather a byte from the master, then acknowledge on the ninth clock
          if (scl_rise && !byte_full) begin
            // sample one bit, msb first
            shift_next = {shift_reg[`BSR_BYTE_MSB-1:0], sda_s};
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            // byte complete: decide on acknowledge
            case (kind_reg)
              BSR_KIND_ADDR: begin
                // only our address gets an acknowledge
                if (addr_hit) begin
                  rw_next = rd_addr;
                  oe_next = 1'b1;
                  st_next = BSR_ACK;
                end else begin
                  st_next = BSR_IDLE;  // other slave, stay off the line
                end
              end
              BSR_KIND_CMD: begin
                // command code is the register index
                cmd_next = shift_reg;
                oe_next  = 1'b1;
                st_next  = BSR_ACK;
              end
              default: begin
                // write data acknowledged and dropped
                oe_next = 1'b1;
                st_next = BSR_ACK;
              end
            endcase
          end
        end
        // ninth clock: hold the acknowledge until the clock falls
        BSR_ACK: begin
          if (scl_fall) begin
            // acknowledge clock done
            bit_next = '0;
            if ((kind_reg == BSR_KIND_ADDR) && rw_reg) begin
              // read byte: present register value, msb first
              shift_next = regs.rd_data;
              // pulling low sends a zero; a one leaves the line to the pull-up
              oe_next    = ~regs.rd_data[`BSR_BYTE_MSB];
              st_next    = BSR_SEND;
            end else begin
              // write direction: release and take the next byte
              oe_next   = 1'b0;
              st_next   = BSR_RECV;
              kind_next = (kind_reg == BSR_KIND_ADDR) ? BSR_KIND_CMD : BSR_KIND_DATA;
            end
          end
        end
        // drive the register value, one bit per clock, msb first
        BSR_SEND: begin
          if (scl_rise) begin
            // master samples the bit on this rise
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_reg == `BSR_BITS_PER_BYTE) begin
              // byte sent, release for master acknowledge
              oe_next = 1'b0;
              st_next = BSR_MACK;
            end else begin
              // move the next bit up while the clock is low
              shift_next = {shift_reg[`BSR_BYTE_MSB-1:0], 1'b0};
              oe_next    = ~shift_reg[`BSR_BYTE_MSB-1];
            end
          end
        end
        BSR_MACK: begin
          // single byte read: any master answer ends the transfer
          // more bytes after a master ack are not supported
          if (scl_rise) begin
            st_next = BSR_IDLE;
          end
        end
        // unused codes fall back to idle with the line released
        default: begin
          st_next = BSR_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // engine and line history registers
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // history starts at the idle level, so no false edge follows reset
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      st_reg    <= BSR_IDLE;
      kind_reg  <= BSR_KIND_ADDR;
      bit_reg   <= '0;
      shift_reg <= `BSR_READ_ZERO;
      cmd_reg   <= `BSR_READ_ZERO;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      // every engine register takes its next value
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      st_reg    <= st_next;
      kind_reg  <= kind_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      cmd_reg   <= cmd_next;
      rw_reg    <= rw_next;
      oe_reg    <= oe_next;
    end
  end

  // open-drain data: only ever pulls low
  // the drive value never changes; only the enable moves the line
  assign o_smb_data_out = 1'b0;
  assign o_smb_data_oe  = oe_reg;
  // state is shown for debug and for the checker
  assign o_state        = st_reg;
endmodule
